// *** design/event_detect.sv ***
// Rising-edge and change detection on synchronised slot levels
`timescale 1ns/100ps

module event_detect #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Levels in, one-cycle events out
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] change_o
);

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("WIDTH must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] change;
    } edge_s;

    edge_s st_ff;
    edge_s nxt_st;

    always_comb
    begin
        nxt_st.prev = level_i;
        nxt_st.rise = level_i & ~st_ff.prev;
        nxt_st.change = level_i ^ st_ff.prev;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            st_ff <= {RESET_VAL, {WIDTH{1'b0}}, {WIDTH{1'b0}}};
        else
            st_ff <= nxt_st;
    end

    assign rise_o = st_ff.rise;
    assign change_o = st_ff.change;

endmodule : event_detect

// *** design/hotplug_slot_pkg.sv ***
// Types shared by the hot-plug slot register bank
package hotplug_slot_pkg;

    // ****************************************************************
    // Bus handshake phase
    // ****************************************************************
    typedef enum logic [0:0] {PH_IDLE, PH_ACK} apb_phase_e;

    // ****************************************************************
    // Register selection
    // ****************************************************************
    typedef enum logic [1:0] {SEL_NONE, SEL_CTL, SEL_STS, SEL_CFG} reg_sel_e;

    typedef logic [15:0] reg16_t;

endpackage : hotplug_slot_pkg

// *** design/hotplug_slot_regs.svh ***
// Register indices, field positions, reset values of the hot-plug slot bank
`ifndef HOTPLUG_SLOT_REGS_SVH
`define HOTPLUG_SLOT_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define HPS_CTL_INDEX 12'h058
`define HPS_STS_INDEX 12'h05a
`define HPS_CFG_INDEX 12'h060

// ****************************************************************
// Slot control fields
// ****************************************************************
`define HPS_CTL_EN_LSB 0
`define HPS_CTL_EN_W 5
`define HPS_CTL_IRQ_EN_BIT 5
`define HPS_CTL_TOGGLE_BIT 11
`define HPS_CTL_RESET 16'h0000

// ****************************************************************
// Slot status fields
// ****************************************************************
`define HPS_STS_BUTTON_BIT 0
`define HPS_STS_PFAULT_BIT 1
`define HPS_STS_LATCH_CHG_BIT 2
`define HPS_STS_PRES_CHG_BIT 3
`define HPS_STS_CMD_DONE_BIT 4
`define HPS_STS_LATCH_BIT 5
`define HPS_STS_PRES_BIT 6
`define HPS_STS_INTLK_BIT 7
`define HPS_STS_FLAGS_RESET 5'h00
`define HPS_STS_LATCH_RESET 1'h0
`define HPS_STS_PRES_RESET 1'h1
`define HPS_STS_INTLK_RESET 1'h0

// ****************************************************************
// Switch and capability configuration fields
// ****************************************************************
`define HPS_CFG_MODE_BIT 0
`define HPS_CFG_INTLK_CAP_BIT 1
`define HPS_CFG_MODE_RESET 1'h1
`define HPS_CFG_INTLK_CAP_RESET 1'h0

`endif

// *** design/hotplug_slot_status_interlock.sv ***
// Hot-plug slot status flags, live slot state and interlock control
//
// Notes on behaviour
// - The interlock control bit always reads back as zero.
// - With an interlock fitted, writing one toggles it; zero does nothing.
// - Control bit is read-only zero if capability off or mode cleared.
// - In legacy mode writes to the interlock control bit are ignored.
// - Button flag, bit 0, sets on press; write one clears; resets zero.
// - Power fault flag, bit 1, sets on fault; write one clears.
// - Latch changed flag, bit 2, sets on any latch sensor change.
// - Presence changed flag, bit 3, sets on any presence change.
// - Command done flag, bit 4, sets when a command finishes.
// - Bit 5 shows live latch state, one is open, resets zero.
// - Bit 6 shows card presence, one is present, resets one.
// - Bit 7 shows interlock state when fitted, one is engaged.
// - Interlock state reads zero in legacy mode.
// - Enabled events that newly set a clear flag raise a hot-plug event when interrupts are enabled.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "hotplug_slot_regs.svh"

module hotplug_slot_status_interlock #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Slot pins, asynchronous
    input wire logic button_i,
    input wire logic power_fault_i,
    input wire logic latch_open_i,
    input wire logic card_present_i,
    // Hot-plug controller, same clock
    input wire logic cmd_done_i,
    // Interlock drive and hot-plug event
    output logic interlock_drive_o,
    output logic hotplug_event_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int TOP_BYTE = 4 * `HPS_CFG_INDEX;

    generate
        if (ADDR_W < $clog2(TOP_BYTE + 1))
        begin : g_narrow_addr
            $error("ADDR_W cannot reach the highest register");
        end
    endgenerate

    generate
        if (ADDR_W > 32)
        begin : g_wide_addr
            $error("ADDR_W must not exceed 32");
        end
    endgenerate

    generate
        if (`HPS_CTL_EN_W != `HPS_STS_CMD_DONE_BIT + 1)
        begin : g_bad_flags
            $error("Flag field must cover status bits 4:0");
        end
    endgenerate

    generate
        if (`HPS_CTL_TOGGLE_BIT > 15 || `HPS_STS_INTLK_BIT > 15)
        begin : g_bad_field
            $error("Field positions must lie in the low half-word");
        end
    endgenerate

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        hotplug_slot_pkg::apb_phase_e phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [`HPS_CTL_EN_W-1:0] event_en;
        logic irq_en;
        logic [`HPS_CTL_EN_W-1:0] flags;
        logic interlock;
        logic mode_sel;
        logic intlk_cap;
        logic event_pulse;
    } hps_state_s;

    localparam hps_state_s RESET_ST = '{
        phase: hotplug_slot_pkg::PH_IDLE,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        event_en: `HPS_CTL_EN_W'(`HPS_CTL_RESET),
        irq_en: 1'b0,
        flags: `HPS_STS_FLAGS_RESET,
        interlock: `HPS_STS_INTLK_RESET,
        mode_sel: `HPS_CFG_MODE_RESET,
        intlk_cap: `HPS_CFG_INTLK_CAP_RESET,
        event_pulse: 1'b0
    };

    localparam logic [3:0] PIN_RESET =
        {`HPS_STS_PRES_RESET, `HPS_STS_LATCH_RESET, 2'h0};

    hps_state_s st_ff;
    hps_state_s nxt_st;

    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_change;

    // ****************************************************************
    // Pin synchronisers and event detection
    // ****************************************************************
    pin_sync #(
        .WIDTH(4),
        .RESET_VAL(PIN_RESET)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({card_present_i, latch_open_i, power_fault_i, button_i}),
        .level_o(pin_level)
    );

    event_detect #(
        .WIDTH(4),
        .RESET_VAL(PIN_RESET)
    ) u_event_detect (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .level_i(pin_level),
        .rise_o(pin_rise),
        .change_o(pin_change)
    );

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [ADDR_W-1:0] byte_addr(
        input logic [11:0] index
    );
        logic [13:0] full;
        full = {index, 2'h0};
        byte_addr = ADDR_W'(full);
    endfunction : byte_addr

    function automatic hotplug_slot_pkg::reg_sel_e decode(
        input logic [ADDR_W-1:0] addr
    );
        if (addr == byte_addr(`HPS_CTL_INDEX))
            decode = hotplug_slot_pkg::SEL_CTL;
        else if (addr == byte_addr(`HPS_STS_INDEX))
            decode = hotplug_slot_pkg::SEL_STS;
        else if (addr == byte_addr(`HPS_CFG_INDEX))
            decode = hotplug_slot_pkg::SEL_CFG;
        else
            decode = hotplug_slot_pkg::SEL_NONE;
    endfunction : decode

    // Expands byte strobes of the low half-word into a bit mask
    function automatic hotplug_slot_pkg::reg16_t lane_mask(
        input logic [3:0] strb
    );
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // Sticky flag update: a set in the clearing cycle survives
    function automatic logic [`HPS_CTL_EN_W-1:0] sticky(
        input logic [`HPS_CTL_EN_W-1:0] cur,
        input logic [`HPS_CTL_EN_W-1:0] set,
        input logic [`HPS_CTL_EN_W-1:0] clr
    );
        sticky = (cur & ~clr) | set;
    endfunction : sticky

    // ****************************************************************
    // Read views of the registers
    // ****************************************************************
    // Interlock fitted and hot-plug mode selected
    function automatic logic intlk_active(
        input hps_state_s s
    );
        intlk_active = s.intlk_cap & s.mode_sel;
    endfunction : intlk_active

    function automatic hotplug_slot_pkg::reg16_t ctl_view(
        input hps_state_s s
    );
        ctl_view = 16'h0000;
        ctl_view[`HPS_CTL_EN_LSB +: `HPS_CTL_EN_W] = s.event_en;
        ctl_view[`HPS_CTL_IRQ_EN_BIT] = s.irq_en;
        ctl_view[`HPS_CTL_TOGGLE_BIT] = 1'b0;
    endfunction : ctl_view

    function automatic hotplug_slot_pkg::reg16_t sts_view(
        input hps_state_s s,
        input logic [1:0] live
    );
        sts_view = 16'h0000;
        sts_view[`HPS_STS_CMD_DONE_BIT:`HPS_STS_BUTTON_BIT] = s.flags;
        sts_view[`HPS_STS_LATCH_BIT] = live[0];
        sts_view[`HPS_STS_PRES_BIT] = live[1];
        sts_view[`HPS_STS_INTLK_BIT] =
            s.interlock & intlk_active(s);
    endfunction : sts_view

    function automatic hotplug_slot_pkg::reg16_t cfg_view(
        input hps_state_s s
    );
        cfg_view = 16'h0000;
        cfg_view[`HPS_CFG_MODE_BIT] = s.mode_sel;
        cfg_view[`HPS_CFG_INTLK_CAP_BIT] = s.intlk_cap;
    endfunction : cfg_view

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        hotplug_slot_pkg::reg_sel_e sel;
        hotplug_slot_pkg::reg16_t wmask;
        hotplug_slot_pkg::reg16_t wbits;
        hotplug_slot_pkg::reg16_t rview;
        logic access;
        logic commit;
        logic wr_ctl;
        logic wr_sts;
        logic wr_cfg;
        logic [`HPS_CTL_EN_W-1:0] ev_set;
        logic [`HPS_CTL_EN_W-1:0] ev_clr;
        logic [`HPS_CTL_EN_W-1:0] fresh;

        nxt_st = st_ff;
        sel = decode(paddr_i);
        wmask = lane_mask(pstrb_i);
        wbits = pwdata_i[15:0] & wmask;
        access = psel_i & penable_i;
        commit = access & st_ff.pready;
        wr_ctl = commit & pwrite_i & (sel == hotplug_slot_pkg::SEL_CTL);
        wr_sts = commit & pwrite_i & (sel == hotplug_slot_pkg::SEL_STS);
        wr_cfg = commit & pwrite_i & (sel == hotplug_slot_pkg::SEL_CFG);
        rview = 16'h0000;

        // Bus handshake: one wait state, then ready for one cycle
        unique case (st_ff.phase)
            hotplug_slot_pkg::PH_IDLE:
            begin
                nxt_st.pready = 1'b0;
                nxt_st.pslverr = 1'b0;
                if (access)
                begin
                    unique case (sel)
                        hotplug_slot_pkg::SEL_CTL: rview = ctl_view(st_ff);
                        hotplug_slot_pkg::SEL_STS:
                            rview = sts_view(st_ff, pin_level[3:2]);
                        hotplug_slot_pkg::SEL_CFG: rview = cfg_view(st_ff);
                        hotplug_slot_pkg::SEL_NONE: rview = 16'h0000;
                    endcase
                    nxt_st.prdata = pwrite_i ? 32'h0000_0000
                        : {16'h0000, rview};
                    nxt_st.pslverr = (sel == hotplug_slot_pkg::SEL_NONE);
                    nxt_st.pready = 1'b1;
                    nxt_st.phase = hotplug_slot_pkg::PH_ACK;
                end
            end
            hotplug_slot_pkg::PH_ACK:
            begin
                nxt_st.pready = 1'b0;
                nxt_st.pslverr = 1'b0;
                nxt_st.phase = hotplug_slot_pkg::PH_IDLE;
            end
        endcase

        // Slot control: event enables and interrupt enable
        if (wr_ctl)
        begin
            nxt_st.event_en = (st_ff.event_en
                & ~wmask[`HPS_CTL_EN_LSB +: `HPS_CTL_EN_W])
                | wbits[`HPS_CTL_EN_LSB +: `HPS_CTL_EN_W];
            if (wmask[`HPS_CTL_IRQ_EN_BIT])
                nxt_st.irq_en = wbits[`HPS_CTL_IRQ_EN_BIT];
        end

        // Interlock toggle on a written one, only when fitted and enabled
        if (wr_ctl && wbits[`HPS_CTL_TOGGLE_BIT]
            && intlk_active(st_ff))
        begin
            nxt_st.interlock = ~st_ff.interlock;
        end

        // Switch configuration: mode selection and interlock capability
        if (wr_cfg)
        begin
            if (wmask[`HPS_CFG_MODE_BIT])
                nxt_st.mode_sel = wbits[`HPS_CFG_MODE_BIT];
            if (wmask[`HPS_CFG_INTLK_CAP_BIT])
                nxt_st.intlk_cap = wbits[`HPS_CFG_INTLK_CAP_BIT];
        end

        // Slot events into sticky flags
        ev_set = 5'h00;
        ev_set[`HPS_STS_BUTTON_BIT] = pin_rise[0];
        ev_set[`HPS_STS_PFAULT_BIT] = pin_rise[1];
        ev_set[`HPS_STS_LATCH_CHG_BIT] = pin_change[2];
        ev_set[`HPS_STS_PRES_CHG_BIT] = pin_change[3];
        ev_set[`HPS_STS_CMD_DONE_BIT] = cmd_done_i;
        ev_clr = wr_sts ? wbits[`HPS_STS_CMD_DONE_BIT:0] : 5'h00;
        nxt_st.flags = sticky(st_ff.flags, ev_set,
            ev_clr);

        // Hot-plug event for an enabled flag that newly becomes set
        fresh = ev_set & ~st_ff.flags & st_ff.event_en;
        nxt_st.event_pulse = st_ff.irq_en & (|fresh);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            st_ff <= RESET_ST;
        else
            st_ff <= nxt_st;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata_o = st_ff.prdata;
    assign pready_o = st_ff.pready;
    assign pslverr_o = st_ff.pslverr;
    assign interlock_drive_o = st_ff.interlock;
    assign hotplug_event_o = st_ff.event_pulse;

endmodule : hotplug_slot_status_interlock

// *** design/pin_sync.sv ***
// Two-stage synchroniser for a group of slot pins
`timescale 1ns/100ps

module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("WIDTH must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s st_ff;
    sync_s nxt_st;

    always_comb
    begin
        nxt_st.stage1 = pin_i;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            st_ff <= {RESET_VAL, RESET_VAL};
        else
            st_ff <= nxt_st;
    end

    assign level_o = st_ff.stage2;

endmodule : pin_sync

// *** verif/hotplug_slot_props.sv ***
// Bus and interlock checks for the hot-plug slot register bank
`timescale 1ns/100ps
`include "hotplug_slot_regs.svh"
module hotplug_slot_props #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Interlock and event
    input wire logic interlock_drive_o,
    input wire logic hotplug_event_o
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    localparam logic [ADDR_W-1:0] CTL_A = ADDR_W'({`HPS_CTL_INDEX, 2'b00});
    localparam logic [ADDR_W-1:0] STS_A = ADDR_W'({`HPS_STS_INDEX, 2'b00});
    localparam logic [ADDR_W-1:0] CFG_A = ADDR_W'({`HPS_CFG_INDEX, 2'b00});
    logic rd_ctl, rd_sts, tgl, cfg_wr, mode_ff, cap_ff;
    assign rd_ctl = pready_o && !pwrite_i && paddr_i == CTL_A;
    assign rd_sts = pready_o && !pwrite_i && paddr_i == STS_A;
    assign cfg_wr = pready_o && pwrite_i && paddr_i == CFG_A && pstrb_i[0];
    assign tgl = pready_o && pwrite_i && paddr_i == CTL_A
        && pwdata_i[`HPS_CTL_TOGGLE_BIT] && pstrb_i[1] && mode_ff && cap_ff;
    // Mode and capability as last written over the bus
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mode_ff <= `HPS_CFG_MODE_RESET;
            cap_ff <= `HPS_CFG_INTLK_CAP_RESET;
        end
        else if (cfg_wr)
        begin
            mode_ff <= pwdata_i[`HPS_CFG_MODE_BIT];
            cap_ff <= pwdata_i[`HPS_CFG_INTLK_CAP_BIT];
        end
    end
    chk_ready_one_wait: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready late");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    chk_ready_cause: assert property (
        pready_o |-> $past(psel_i && penable_i))
        else $error("ready without access");
    chk_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_err_no_data: assert property (
        pslverr_o |-> prdata_o == 32'h0)
        else $error("error with data");
    chk_upper_half_zero: assert property (
        pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0)
        else $error("upper half set");
    chk_ctl_top_zero: assert property (
        rd_ctl |-> prdata_o[15:11] == 5'h0)
        else $error("control top bits set");
    chk_sts_rsvd_zero: assert property (
        rd_sts |-> prdata_o[15:8] == 8'h0)
        else $error("status reserved set");
    chk_intlk_by_write: assert property (
        !$stable(interlock_drive_o) |-> $past(tgl))
        else $error("interlock moved alone");
    chk_intlk_toggles: assert property (
        tgl |=> interlock_drive_o != $past(interlock_drive_o))
        else $error("interlock did not toggle");
    chk_sts_intlk_bit: assert property (
        rd_sts |-> prdata_o[`HPS_STS_INTLK_BIT]
            == (interlock_drive_o && mode_ff && cap_ff))
        else $error("interlock status wrong");
    cover property (rd_sts);
    cover property (tgl);
    cover property (pslverr_o);
    cover property (hotplug_event_o);
endmodule : hotplug_slot_props

bind hotplug_slot_status_interlock hotplug_slot_props #(
    .ADDR_W(ADDR_W)
) u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .interlock_drive_o(interlock_drive_o),
    .hotplug_event_o(hotplug_event_o)
);

// *** verif/slot_pins.sv ***
// Slot pin model: button, power fault, latch, presence, command done
`timescale 1ns/100ps
module slot_pins (
    // Clock
    input wire logic clk_i,
    // Pins toward the block
    output logic button_o,
    output logic fault_o,
    output logic latch_o,
    output logic card_o,
    output logic done_o
);
    initial
    begin
        button_o = 1'b0;
        fault_o = 1'b0;
        latch_o = 1'b0;
        card_o = 1'b1;
        done_o = 1'b0;
    end
    // One slot event; button and fault held four cycles
    task automatic fire(input int k);
        @(posedge clk_i);
        case (k)
            0: button_o <= 1'b1;
            1: fault_o <= 1'b1;
            2: latch_o <= ~latch_o;
            3: card_o <= ~card_o;
            default: done_o <= 1'b1;
        endcase
        @(posedge clk_i);
        done_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        button_o <= 1'b0;
        fault_o <= 1'b0;
    endtask : fire
endmodule : slot_pins

// *** verif/testbench.sv ***
// Self-checking bench for the hot-plug slot register bank
`timescale 1ns/100ps
module testbench;
    // ********
    // Signals
    // ********
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, btn, pf, latch, card, done, drive, evt;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int events = 0;
    // Byte addresses, four times the register index
    localparam logic [11:0] CTL = 12'h160;
    localparam logic [11:0] STS = 12'h168;
    localparam logic [11:0] CFG = 12'h180;
    always #12.5 clk_i = ~clk_i;
    hotplug_slot_status_interlock u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .button_i(btn),
        .power_fault_i(pf), .latch_open_i(latch), .card_present_i(card),
        .cmd_done_i(done), .interlock_drive_o(drive),
        .hotplug_event_o(evt)
    );
    slot_pins u_slot (
        .clk_i(clk_i), .button_o(btn), .fault_o(pf), .latch_o(latch),
        .card_o(card), .done_o(done)
    );
    // ********
    // Tasks
    // ********
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk(nm, exp, rd);
    endtask : rchk
    task automatic dchk(input string nm, input logic exp);
        @(negedge clk_i);
        chk(nm, {31'h0, exp}, {31'h0, drive});
    endtask : dchk
    function automatic logic [31:0] live(input logic il);
        live = {24'h0, il, card, latch, 5'h0};
    endfunction : live
    always @(posedge clk_i)
    begin
        cycles++;
        if (evt === 1'b1)
            events++;
        if (cycles == 6000)
        begin
            errors++;
            end_of_test();
        end
    end
    // ********
    // Tests
    // ********
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rchk("status reset", STS, 32'h40);
        rchk("control reset", CTL, 32'h0);
        rchk("config reset", CFG, 32'h1);
        rchk("unmapped read", 12'h164, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        for (int i = 0; i < 5; i++)
        begin
            u_slot.fire(i);
            repeat (4) @(posedge clk_i);
            rchk("flag set", STS, live(1'b0) | (32'h1 << i));
            wr(STS, 32'h0);
            rchk("flag kept", STS, live(1'b0) | (32'h1 << i));
            wr(STS, 32'hff00 | (32'h1 << i));
            rchk("flag cleared", STS, live(1'b0));
        end
        wr(CTL, 32'h800);
        dchk("no capability", 1'b0);
        wr(CFG, 32'h3);
        wr(CTL, 32'h800);
        dchk("toggled on", 1'b1);
        rchk("toggle reads zero", CTL, 32'h0);
        rchk("engaged", STS, live(1'b1));
        wr(CTL, 32'h0);
        dchk("zero write", 1'b1);
        xfer(1'b1, CTL, 32'h800, 4'h1);
        dchk("lane skipped", 1'b1);
        wr(CFG, 32'h2);
        rchk("legacy status", STS, live(1'b0));
        wr(CTL, 32'h800);
        dchk("legacy write", 1'b1);
        wr(CFG, 32'h3);
        wr(CTL, 32'h800);
        dchk("toggled off", 1'b0);
        wr(CTL, 32'hf000);
        rchk("control reserved", CTL, 32'h0);
        wr(CTL, 32'h21);
        rchk("enables", CTL, 32'h21);
        events = 0;
        u_slot.fire(0);
        repeat (6) @(posedge clk_i);
        chk("event enabled", 32'h1, 32'(events));
        wr(STS, 32'h1);
        wr(CTL, 32'h1);
        events = 0;
        u_slot.fire(0);
        repeat (6) @(posedge clk_i);
        chk("event masked", 32'h0, 32'(events));
        end_of_test();
    end
endmodule : testbench
